/* File: verilog/ips_sequencer.sv */
// Overview of operation
// [RQ1] Oscillator divided into four rotating phases
// [RQ2] Program counter increments in first phase
// [RQ3] Program word latched in fourth phase
// [RQ4] Instruction held through execute phases two-four
// [RQ5] Data read phase two, write phase four
// [RQ6] Fetch overlaps execute, one per cycle
// [RQ7] Branches flush fetched word, take two cycles
// [RQ8] Program counter is thirteen bits wide
// [RQ9] Addresses above 0FFF wrap onto implemented range
// [RQ10] Reset vector zero, interrupt vector four
// [RQ11] Reset restarts phases, pipeline empty
`timescale 1ns/1ps
`default_nettype none
module ips_sequencer (
  // Clock and reset
  input  wire logic                            ref_clk_in,
  input  wire logic                            reset_in,
  // Phase state
  output logic [3:0]                           phase_out,
  // Program memory
  output logic [ips_pkg::IMPL_ADDR_W-1:0]      prog_addr_out,
  output logic                                 prog_rd_out,
  input  wire logic [ips_pkg::WORD_W-1:0]      prog_word_in,
  // Execute unit
  output logic [ips_pkg::WORD_W-1:0]           instr_out,
  output logic                                 instr_valid_out,
  output logic [ips_pkg::PC_W-1:0]             program_counter_out,
  input  wire logic                            branch_req_in,
  input  wire logic [ips_pkg::PC_W-1:0]        branch_target_in,
  input  wire logic                            wr_req_in,
  input  wire logic [ips_pkg::DATA_W-1:0]      wr_data_in,
  output logic [ips_pkg::DATA_W-1:0]           operand_out,
  // Interrupt and redirect flush
  input  wire logic                            irq_in,
  output logic                                 irq_ack_out,
  output logic                                 flush_out,
  // Data memory
  output logic [ips_pkg::DADDR_W-1:0]          data_addr_out,
  output logic                                 data_rd_out,
  input  wire logic [ips_pkg::DATA_W-1:0]      data_rd_data_in,
  output logic                                 data_wr_out,
  output logic [ips_pkg::DATA_W-1:0]           data_wr_data_out
);
  import ips_pkg::*;

  ips_phase_t          phase;
  logic [3:0]          phase_onehot;
  logic [PC_W-1:0]     pc;

  // Phase decode
  wire in_first  = (phase == phase_first);
  wire in_second = (phase == phase_second);
  wire in_third  = (phase == phase_third);
  wire in_fourth = (phase == phase_fourth);

  // Interrupt beats a branch; the stack that saves the return is elsewhere
  wire take_irq    = in_fourth && irq_in;
  wire take_branch = in_fourth && instr_valid_out && branch_req_in && !irq_in;
  wire redirect    = take_irq || take_branch;

  wire [PC_W-1:0] next_pc =
      take_irq    ? IRQ_VECTOR :                                      // [RQ10]
      take_branch ? branch_target_in :                                // [RQ7]
      in_first    ? PC_W'(pc + 13'd1) :                               // [RQ2] [RQ8]
                    pc;

  // Upper address bit dropped so high fetches alias the low 4K
  wire [IMPL_ADDR_W-1:0] fetch_addr = pc[IMPL_ADDR_W-1:0];            // [RQ9]

  wire next_data_rd = in_first && instr_valid_out;                    // [RQ5]
  wire next_data_wr = in_third && instr_valid_out && wr_req_in;       // [RQ5]

  ips_phase_gen u_phase (
    .ref_clk_in       (ref_clk_in),
    .reset_in         (reset_in),
    .phase_out        (phase),
    .phase_onehot_out (phase_onehot)
  );                                                                  // [RQ1]

  assign phase_out           = phase_onehot;
  assign program_counter_out = pc;

  // Program counter and fetch address
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      pc            <= RESET_VECTOR;                                  // [RQ10]
      prog_addr_out <= RESET_VECTOR[IMPL_ADDR_W-1:0];
      prog_rd_out   <= 1'b0;
    end else begin
      pc <= next_pc;
      if (in_first) begin
        prog_addr_out <= fetch_addr;                                  // [RQ9]
      end
      prog_rd_out <= in_first;
    end
  end

  // Instruction register; a redirect voids the word in flight
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      instr_out       <= IR_RESET;
      instr_valid_out <= 1'b0;                                        // [RQ11]
    end else if (in_fourth) begin
      instr_out       <= prog_word_in;                                // [RQ3] [RQ6]
      instr_valid_out <= !redirect;                                   // [RQ7]
    end
  end

  // Event pulses
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      irq_ack_out <= 1'b0;
      flush_out   <= 1'b0;
    end else begin
      irq_ack_out <= take_irq;
      flush_out   <= redirect;
    end
  end

  // Data memory strobes, operand address from the low opcode bits
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      data_addr_out    <= '0;
      data_rd_out      <= 1'b0;
      data_wr_out      <= 1'b0;
      data_wr_data_out <= DATA_RESET;
      operand_out      <= DATA_RESET;
    end else begin
      if (in_first) begin
        data_addr_out <= instr_out[DADDR_W-1:0];                      // [RQ4]
      end
      data_rd_out <= next_data_rd;
      data_wr_out <= next_data_wr;
      if (in_third) begin
        data_wr_data_out <= wr_data_in;
      end
      if (data_rd_out) begin
        operand_out <= data_rd_data_in;                               // [RQ5]
      end
    end
  end

  // Checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);

  sequence s_phase_walk;
    in_second ##1 in_third ##1 in_fourth ##1 in_first;
  endsequence

  sequence s_flushed_cycle;
    (!instr_valid_out) [*4];
  endsequence

  a_phase_walk_order: assert property (in_first |=> s_phase_walk) // [RQ1]
    else $error("phase sequence out of order");

  a_phase_onehot_match: assert property (
    $onehot(phase_out) && phase_out[phase] == 1'b1) // [RQ1]
    else $error("one-hot phase disagrees with phase state");

  a_pc_first_step: assert property (
    in_first |=> pc == PC_W'($past(pc) + 13'd1)) // [RQ2]
    else $error("program counter did not step in first phase");

  a_pc_hold_mid: assert property (
    (in_second || in_third) |=> $stable(pc)) // [RQ2]
    else $error("program counter moved outside first or fourth phase");

  a_ir_fourth_load: assert property (
    (in_fourth && !redirect) |=> instr_out == $past(prog_word_in) && instr_valid_out) // [RQ3]
    else $error("instruction not latched in fourth phase");

  a_ir_exec_hold: assert property (
    !in_fourth |=> $stable(instr_out) && $stable(instr_valid_out)) // [RQ4]
    else $error("instruction changed during execution");

  a_data_rd_phase: assert property (
    data_rd_out |-> in_second && instr_valid_out) // [RQ5]
    else $error("data read outside second phase");

  a_data_wr_phase: assert property (
    data_wr_out |-> in_fourth && instr_valid_out) // [RQ5]
    else $error("data write outside fourth phase");

  a_rd_each_cycle: assert property (
    (in_first && instr_valid_out) |=> data_rd_out ##1 !data_rd_out) // [RQ6]
    else $error("operand read missing for valid instruction");

  a_branch_two_cycle: assert property (
    take_branch |=> pc == $past(branch_target_in) && flush_out ##0 s_flushed_cycle) // [RQ7]
    else $error("branch did not flush the fetched word");

  a_fetch_wraps: assert property (
    in_second |-> prog_addr_out == IMPL_ADDR_W'(pc - 13'd1) && prog_rd_out) // [RQ9] [RQ8]
    else $error("fetch address not wrapped onto implemented range");

  a_irq_vector_load: assert property (
    take_irq |=> pc == IRQ_VECTOR && irq_ack_out ##1 !irq_ack_out) // [RQ10]
    else $error("interrupt did not load vector four");

  a_reset_start: assert property (
    $fell(reset_in) |-> in_first && pc == RESET_VECTOR && !instr_valid_out) // [RQ11] [RQ10]
    else $error("state after reset wrong");

  // Strobe shapes across one instruction cycle
  sequence s_fetch_strobe;
    prog_rd_out ##1 (!prog_rd_out) [*3];
  endsequence

  sequence s_write_slot;
    !data_wr_out ##1 data_wr_out ##1 !data_wr_out;
  endsequence

  a_prog_rd_pulse: assert property ( // [RQ6]
    in_first |=> s_fetch_strobe)
    else $error("fetch strobe not a single second-phase pulse");

  a_wr_slot_shape: assert property ( // [RQ5]
    (in_third && instr_valid_out && wr_req_in) |-> s_write_slot)
    else $error("destination write not confined to fourth phase");

  a_prog_rd_phase: assert property ( // [RQ6]
    prog_rd_out |-> in_second)
    else $error("fetch strobe outside second phase");

  a_addr_hold_fetch: assert property ( // [RQ9]
    !in_first |=> $stable(prog_addr_out))
    else $error("fetch address moved mid fetch");

  a_flush_one_cycle: assert property ( // [RQ7]
    flush_out |=> !flush_out)
    else $error("flush pulse longer than one cycle");

  a_flush_in_first: assert property ( // [RQ7]
    flush_out |-> in_first)
    else $error("flush pulse outside first phase");

  a_flush_needs_redirect: assert property ( // [RQ7]
    (in_fourth && !redirect) |=> !flush_out)
    else $error("flush without a redirect");

  a_redirect_void: assert property ( // [RQ7]
    redirect |=> !instr_valid_out && instr_out == $past(prog_word_in))
    else $error("word fetched at redirect not voided");

  a_no_rd_invalid: assert property ( // [RQ7]
    (in_first && !instr_valid_out) |=> !data_rd_out)
    else $error("operand read for flushed instruction");

  a_branch_ignored: assert property ( // [RQ7]
    (in_fourth && !instr_valid_out && !irq_in) |=> pc == $past(pc))
    else $error("branch taken from a flushed instruction");

  a_irq_beats_branch: assert property ( // [RQ10]
    (in_fourth && irq_in && branch_req_in) |=> pc == IRQ_VECTOR)
    else $error("branch won over interrupt");

  a_ack_in_first: assert property ( // [RQ10]
    irq_ack_out |-> in_first && flush_out)
    else $error("interrupt acknowledge misplaced");

  a_ack_only_fourth: assert property ( // [RQ10]
    !in_fourth |=> !irq_ack_out)
    else $error("interrupt taken outside fourth phase");

  a_pc_wrap_top: assert property ( // [RQ8]
    (in_first && pc == 13'h1FFF) |=> pc == 13'h0000)
    else $error("program counter did not wrap at thirteen bits");

  a_phase_return: assert property ( // [RQ1]
    phase_out[3] |=> phase_out[0])
    else $error("fourth phase not followed by first");

  a_daddr_load: assert property ( // [RQ4]
    in_first |=> data_addr_out == $past(instr_out[DADDR_W-1:0]))
    else $error("operand address not taken from instruction");

  a_daddr_hold: assert property ( // [RQ4]
    !in_first |=> $stable(data_addr_out))
    else $error("operand address moved during execution");

  a_operand_capture: assert property ( // [RQ5]
    data_rd_out |=> operand_out == $past(data_rd_data_in))
    else $error("operand not captured at end of read");

  a_operand_hold: assert property ( // [RQ5]
    !data_rd_out |=> $stable(operand_out))
    else $error("operand changed without a read");

  a_wr_data_load: assert property ( // [RQ5]
    in_third |=> data_wr_data_out == $past(wr_data_in))
    else $error("write data not taken in third phase");

  a_wr_data_hold: assert property ( // [RQ5]
    !in_third |=> $stable(data_wr_data_out))
    else $error("write data changed outside third phase");

  a_strobes_quiet_third: assert property ( // [RQ5]
    in_second |=> !data_rd_out && !data_wr_out)
    else $error("data strobe active in third phase");

endmodule : ips_sequencer
`default_nettype wire

/* File: verilog/ips_pkg.sv */
`default_nettype none
package ips_pkg;

  // Oscillator periods per instruction cycle
  localparam int unsigned PHASE_COUNT = 4;

  // Program side
  localparam int unsigned PC_W        = 13;
  localparam int unsigned IMPL_ADDR_W = 12;
  localparam int unsigned WORD_W      = 14;

  // Data side
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned DADDR_W     = 7;

  // Vectors and values after reset
  localparam logic [PC_W-1:0]   RESET_VECTOR = 13'h0000;
  localparam logic [PC_W-1:0]   IRQ_VECTOR   = 13'h0004;
  localparam logic [WORD_W-1:0] IR_RESET     = 14'h0000;
  localparam logic [DATA_W-1:0] DATA_RESET   = 8'h00;

  typedef enum logic [1:0] {
    phase_first,
    phase_second,
    phase_third,
    phase_fourth
  } ips_phase_t;

endpackage : ips_pkg
`default_nettype wire

/* File: verilog/ips_phase_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module ips_phase_gen (
  // Clock and reset
  input  wire logic               ref_clk_in,
  input  wire logic               reset_in,
  // Phase state
  output ips_pkg::ips_phase_t     phase_out,
  output logic [3:0]              phase_onehot_out
);
  import ips_pkg::*;

  ips_phase_t next_phase;

  assign next_phase = (phase_out == phase_fourth) ? phase_first
                                                  : ips_phase_t'(phase_out + 2'd1);

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      phase_out        <= phase_first;
      phase_onehot_out <= 4'h1;
    end else begin
      phase_out        <= next_phase;
      phase_onehot_out <= {phase_onehot_out[2:0], phase_onehot_out[3]};
    end
  end

endmodule : ips_phase_gen
`default_nettype wire

/* File: verification/ips_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ips_mem_model (
  // Clock
  input  wire logic        ref_clk_in,
  // Program side
  input  wire logic [11:0] prog_addr_in,
  output logic      [13:0] prog_word_out,
  // Data side
  input  wire logic [6:0]  data_addr_in,
  input  wire logic        data_wr_in,
  input  wire logic [7:0]  data_wr_data_in,
  output logic      [7:0]  data_rd_data_out
);
  logic [7:0] mem [128];
  // Word carries its own address, so a wrapped fetch is visible
  assign prog_word_out    = {2'b01, prog_addr_in};
  assign data_rd_data_out = mem[data_addr_in];
  initial begin
    for (int i = 0; i < 128; i++) begin
      mem[i] = 8'h5A ^ i[7:0];
    end
  end
  always @(posedge ref_clk_in) begin
    if (data_wr_in) begin
      mem[data_addr_in] <= data_wr_data_in;
    end
  end
endmodule : ips_mem_model
`default_nettype wire

/* File: verification/instruction_phase_sequencer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module instruction_phase_sequencer_tb;
  logic        clk, rst, prd, ivld, brq, wrq, irq, ack, fl, drd, dwr;
  logic [3:0]  ph;
  logic [11:0] pa;
  logic [13:0] pw, ins;
  logic [12:0] pc, bt;
  logic [7:0]  wd, opd, dd, dwd;
  logic [6:0]  da;
  int          err_total, checks;

  ips_sequencer i_ips_sequencer (.ref_clk_in(clk), .reset_in(rst), .phase_out(ph),
    .prog_addr_out(pa), .prog_rd_out(prd), .prog_word_in(pw), .instr_out(ins),
    .instr_valid_out(ivld), .program_counter_out(pc), .branch_req_in(brq),
    .branch_target_in(bt), .wr_req_in(wrq), .wr_data_in(wd), .operand_out(opd),
    .irq_in(irq), .irq_ack_out(ack), .flush_out(fl), .data_addr_out(da),
    .data_rd_out(drd), .data_rd_data_in(dd), .data_wr_out(dwr), .data_wr_data_out(dwd));
  ips_mem_model i_ips_mem_model (.ref_clk_in(clk), .prog_addr_in(pa), .prog_word_out(pw),
    .data_addr_in(da), .data_wr_in(dwr), .data_wr_data_in(dwd), .data_rd_data_out(dd));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Bounded wait for a phase, seen at the falling edge
  task automatic at_phase(input logic [3:0] p);
    @(negedge clk);
    for (int n = 0; n < 8 && ph !== p; n++) begin
      @(negedge clk);
    end
    chk(ph, p);
  endtask : at_phase

  task automatic give_verdict;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict

  task automatic t_reset_fetch;
    rst = 1'b0;
    chk(ph, 4'b0001);
    chk(ivld, 1'b0);
    chk(pc, 13'h0000);
    for (int i = 1; i < 4; i++) begin
      @(negedge clk);
      chk(ph, 4'b0001 << i);
      if (i == 1) begin
        chk(pc, 13'h0001);
        chk({prd, pa}, 13'h1000);
      end
    end
    at_phase(4'b0001);
    chk({ivld, ins}, 15'h5000);
    $display("test reset_fetch done");
  endtask : t_reset_fetch

  task automatic t_branch_wrap;
    at_phase(4'b1000);
    brq = 1'b1;
    bt  = 13'h1FFE;
    @(negedge clk);
    brq = 1'b0;
    chk({fl, ivld, pc}, 15'h5FFE);
    @(negedge clk);
    chk(pa, 12'hFFE);
    chk(pc, 13'h1FFF);
    at_phase(4'b0001);
    chk({ivld, ins}, 15'h5FFE);
    @(negedge clk);
    chk(pa, 12'hFFF);
    chk(pc, 13'h0000);
    $display("test branch_wrap done");
  endtask : t_branch_wrap

  task automatic t_irq_data;
    at_phase(4'b1000);
    irq = 1'b1;
    brq = 1'b1;
    bt  = 13'h0100;
    @(negedge clk);
    {irq, brq} = 2'b00;
    chk({ack, fl, pc}, 15'h6004);
    at_phase(4'b0001);
    chk({ivld, ins}, 15'h5004);
    @(negedge clk);
    chk({drd, dwr}, 2'b10);
    @(negedge clk);
    chk(opd, 8'h5E);
    chk(da, 7'h04);
    wrq = 1'b1;
    wd  = 8'hA5;
    @(negedge clk);
    wrq = 1'b0;
    chk({drd, dwr, dwd}, 10'h1A5);
    $display("test irq_data done");
  endtask : t_irq_data

  initial begin
    {err_total, checks} = 0;
    {rst, brq, wrq, irq} = 4'b1000;
    bt = 13'h0000;
    wd = 8'h00;
    repeat (5) @(negedge clk);
    t_reset_fetch();
    t_branch_wrap();
    t_irq_data();
    give_verdict();
  end

  // Whole run needs well under 100 cycles
  initial begin
    #5000;
    err_total++;
    give_verdict();
  end
endmodule : instruction_phase_sequencer_tb
`default_nettype wire
